// ===== rtl/irq_watchdog_sleep_ctrl.sv
// Interrupt flags, watchdog with shared prescaler, and sleep entry and wake-up control.
//
// Operation
// R1 - Timer rollover from maximum to zero sets the overflow flag, control bit 2.
// R2 - Overflow flag sets regardless of enables and stays until software clears it.
// R3 - External pin edge, rising or falling per option bit 6, sets control bit 1.
// R4 - Software masks via bit 4 and clears the flag before re-enabling.
// R5 - Enabled external edge wakes from sleep; global enable decides vectoring.
// R6 - Any change on three monitored pins sets bit 0, cleared only by software.
// R7 - Interrupt entry saves only the return address; software saves other context.
// R8 - Watchdog counts on its own time base, also during sleep.
// R9 - Timeout resets the device when awake, wakes it when asleep.
// R10 - Cleared configuration enable bit 3 disables the watchdog permanently.
// R11 - Nominal 18 ms period; prescaler assignable for division up to 1:128.
// R12 - Watchdog clear and sleep reset the counter and an assigned prescaler.
// R13 - Every watchdog timeout clears the active-low timeout status bit; the code leaves it set for a timeout in MODE_WAKE or with a watchdog clear.
// R14 - Software clears the watchdog before changing an assigned prescale value.
// R15 - Sleep clears the watchdog, clears power-down, sets timeout, stops oscillator.
// R16 - During sleep all pins hold their previous drive state.
// R17 - Reset pin resets; watchdog, pin, port change or peripheral events wake.
// R18 - Power-down bit set at power-up, cleared by sleep; timeout marks watchdog wake.
// R19 - Only conversion completion on the RC clock can wake as a peripheral.
// R20 - Sleep prefetches next instruction; wake needs the source enable only.
// R21 - Global enable clear resumes in line; set vectors to 0004h after one instruction.
// R22 - Software places a no-operation after sleep if prefetch execution is unwanted.
// R23 - Global enable bit 7 gates every unmasked interrupt onto the vector request.
// R24 - Responding clears global enable and loads the vector; return sets it again.
// R25 - External event to vector takes three or four instruction cycles.
// R26 - Assignment bit routes prescaler to watchdog when set; three bits pick ratio.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module irq_watchdog_sleep_ctrl
  import irq_wdt_pkg::*;
#(
  parameter int unsigned WDT_CYCLES = irq_wdt_pkg::WDT_CYCLES_NOM
) (
  input  wire logic                    mclk_i,
  input  wire logic                    reset_i,
  input  wire irq_wdt_pkg::reg_req_t   reg_req_i,
  output logic [7:0]                   reg_rdata_o,
  input  wire irq_wdt_pkg::core_cmd_t  core_cmd_i,
  input  wire logic                    timer_rollover_i,
  input  wire logic                    ext_irq_pin_i,
  input  wire logic                    port_pin_zero_i,
  input  wire logic                    port_pin_one_i,
  input  wire logic                    port_pin_three_i,
  input  wire logic                    conversion_done_flag_i,
  input  wire logic                    conversion_irq_enable_i,
  input  wire logic                    conversion_rc_clock_i,
  input  wire logic [7:0]              config_word_i,
  output logic                         irq_req_o,
  output logic                         vector_load_o,
  output logic [12:0]                  vector_addr_o,
  output logic                         wdt_reset_o,
  output logic                         wake_o,
  output logic                         osc_stop_o,
  output logic                         pin_hold_o
);
  import irq_wdt_pkg::*;

  typedef struct packed {
    mode_t                mode;
    logic [7:0]           irq_ctrl;
    logic [7:0]           option;
    logic [7:0]           cfg;
    logic                 cfg_valid;
    logic                 to_n;
    logic                 pd_n;
    logic [WDT_CNT_W-1:0] wdt_cnt;
    logic [7:0]           psc;
    logic                 ext_prev;
    logic [2:0]           pins_prev;
    logic                 prev_valid;
    logic [7:0]           rdata;
    logic                 irq_req;
    logic                 vector_load;
    logic [12:0]          vector_addr;
    logic                 wdt_reset;
    logic                 wake;
    logic                 osc_stop;
    logic                 pin_hold;
  } state_t;

  state_t state_q;
  state_t state_d;

  function automatic logic [7:0] ratio_mask(input logic [2:0] ps);
    ratio_mask = 8'(~(8'hff << ps));
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] offs);
    addr_is = (a == offs);
  endfunction

  logic       wdt_on;
  logic       base_tick;
  logic       wdt_timeout;
  logic       ext_edge;
  logic       pin_change;
  logic       periph_wake;
  logic       wake_pending;
  logic       tmr_pending;
  logic       ext_pending;
  logic       port_pending;
  logic       periph_pending;
  logic [2:0] pins_now;


  assign pins_now = {port_pin_three_i, port_pin_one_i, port_pin_zero_i};

  always_comb begin
    state_d = state_q;
    state_d.vector_load = 1'b0;
    state_d.wdt_reset = 1'b0;
    state_d.wake = 1'b0;
    state_d.rdata = 8'h00;

    // The configuration word is caught once after reset release and never changes again.
    if (!state_q.cfg_valid) begin
      state_d.cfg = config_word_i;
      state_d.cfg_valid = 1'b1;
    end
    wdt_on = state_q.cfg_valid && state_q.cfg[CFG_WDT_EN_BIT]; // R10

    // The base count runs in every mode, so sleep never stops the watchdog.
    base_tick = wdt_on && (state_q.wdt_cnt == WDT_CNT_W'(WDT_CYCLES - 1)); // R8 R11
    wdt_timeout = 1'b0;
    if (!wdt_on) begin
      state_d.wdt_cnt = '0;
      state_d.psc = '0;
    end else if (base_tick) begin
      state_d.wdt_cnt = '0;
      if (state_q.option[OPT_ASSIGN_BIT]) begin // R26
        if ((state_q.psc & ratio_mask(state_q.option[OPT_PS_LSB +: 3])) ==
            ratio_mask(state_q.option[OPT_PS_LSB +: 3])) begin // R11
          wdt_timeout = 1'b1;
          state_d.psc = '0;
        end else begin
          state_d.psc = state_q.psc + 8'h01;
        end
      end else begin
        wdt_timeout = 1'b1;
      end
    end else begin
      state_d.wdt_cnt = state_q.wdt_cnt + WDT_CNT_W'(1);
    end

    // Edge and change detectors need one sampled cycle before they may fire.
    ext_edge = 1'b0;
    if (state_q.prev_valid) begin
      if (state_q.option[OPT_EDGE_BIT]) begin
        ext_edge = ext_irq_pin_i && !state_q.ext_prev; // R3
      end else begin
        ext_edge = !ext_irq_pin_i && state_q.ext_prev; // R3
      end
    end
    pin_change = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (state_q.prev_valid && (pins_now[i] != state_q.pins_prev[i])) begin
        pin_change = 1'b1; // R6
      end
    end
    state_d.ext_prev = ext_irq_pin_i;
    state_d.pins_prev = pins_now;
    state_d.prev_valid = 1'b1;

    // A software write lands first; hardware sets are ORed after it so a set wins.
    if (reg_req_i.wr) begin
      if (addr_is(reg_req_i.addr, IRQ_CTRL_OFFS)) begin
        state_d.irq_ctrl = reg_req_i.wdata; // R4
      end else if (addr_is(reg_req_i.addr, OPTION_OFFS)) begin
        state_d.option = reg_req_i.wdata; // R26
      end else if (addr_is(reg_req_i.addr, STATUS_OFFS)) begin
        // Status bits move only on hardware events, so software cannot fake a wake cause.
        state_d.pd_n = state_q.pd_n;
      end else if (addr_is(reg_req_i.addr, CONFIG_OFFS)) begin
        state_d.cfg = state_q.cfg;
      end
    end

    if (timer_rollover_i) begin
      state_d.irq_ctrl[FLAG_TMR_BIT] = 1'b1; // R1 R2
    end
    if (ext_edge) begin
      state_d.irq_ctrl[FLAG_EXT_BIT] = 1'b1; // R3
    end
    if (pin_change) begin
      state_d.irq_ctrl[FLAG_PORT_BIT] = 1'b1; // R6
    end

    // Only conversion completion on its own RC clock survives sleep as a peripheral source.
    periph_wake = conversion_done_flag_i && conversion_irq_enable_i &&
                  (conversion_rc_clock_i || state_q.mode == MODE_RUN); // R19
    // The global enable is left out on purpose: wake-up needs the source enable only.
    tmr_pending = state_q.irq_ctrl[FLAG_TMR_BIT] && state_q.irq_ctrl[EN_TMR_BIT];
    ext_pending = state_q.irq_ctrl[FLAG_EXT_BIT] && state_q.irq_ctrl[EN_EXT_BIT]; // R5
    port_pending = state_q.irq_ctrl[FLAG_PORT_BIT] && state_q.irq_ctrl[EN_PORT_BIT];
    periph_pending = periph_wake && state_q.irq_ctrl[EN_PERIPH_BIT]; // R19
    wake_pending = tmr_pending || ext_pending ||
                   port_pending || periph_pending; // R5 R20


    case (state_q.mode)
      MODE_RUN: begin
        if (core_cmd_i.watchdog_clear_instr) begin
          state_d.wdt_cnt = '0; // R12
          if (state_q.option[OPT_ASSIGN_BIT]) begin
            state_d.psc = '0;
          end
          state_d.to_n = 1'b1;
          state_d.pd_n = 1'b1;
        end
        if (wdt_timeout && !core_cmd_i.watchdog_clear_instr) begin
          // A timeout while awake restarts the device; status keeps the cause.
          state_d.wdt_reset = 1'b1; // R9
          state_d.to_n = 1'b0; // R13
          state_d.irq_ctrl = IRQ_CTRL_RESET;
          state_d.option = OPTION_RESET;
          state_d.wdt_cnt = '0;
          state_d.psc = '0;
        end else if (core_cmd_i.sleep && !wake_pending) begin
          // With an enabled source already pending, sleep completes as a no-operation.
          state_d.wdt_cnt = '0; // R12 R15
          if (state_q.option[OPT_ASSIGN_BIT]) begin
            state_d.psc = '0;
          end
          state_d.pd_n = 1'b0; // R15 R18
          state_d.to_n = 1'b1; // R15
          state_d.osc_stop = 1'b1; // R15
          state_d.pin_hold = 1'b1; // R16
          state_d.mode = MODE_SLEEP;
        end
      end

      MODE_SLEEP: begin
        // A timeout is checked first so that the status shows it as the wake cause.
        if (wdt_timeout) begin
          state_d.to_n = 1'b0; // R9 R13 R18
          state_d.mode = MODE_WAKE;
        end else if (ext_pending) begin
          state_d.mode = MODE_WAKE; // R5 R20
        end else if (port_pending) begin
          state_d.mode = MODE_WAKE; // R17
        end else if (periph_pending) begin
          state_d.mode = MODE_WAKE; // R19
        end else if (tmr_pending) begin
          state_d.mode = MODE_WAKE; // R20
        end
      end

      MODE_WAKE: begin
        // Execution resumes with the prefetched instruction; vectoring follows via irq_req.
        state_d.osc_stop = 1'b0;
        state_d.pin_hold = 1'b0;
        state_d.wake = 1'b1; // R17 R21
        state_d.mode = MODE_RUN;
      end

      default: begin
        state_d.mode = MODE_RUN;
      end
    endcase

    if (core_cmd_i.return_from_irq_instr) begin
      state_d.irq_ctrl[GIE_BIT] = 1'b1; // R24
    end
    if (core_cmd_i.irq_take && state_q.irq_req) begin
      // The core pushes only its return address; nothing else is saved here.
      state_d.irq_ctrl[GIE_BIT] = 1'b0; // R7 R24
      state_d.vector_load = 1'b1;
      state_d.vector_addr = IRQ_VECTOR; // R21
    end

    // Registered request gives a fixed path so event to vector lands in the stated window.
    state_d.irq_req = state_d.irq_ctrl[GIE_BIT] && wake_pending &&
                      state_d.mode == MODE_RUN; // R23 R25

    if (reg_req_i.rd) begin
      if (addr_is(reg_req_i.addr, STATUS_OFFS)) begin
        state_d.rdata[STAT_TO_BIT] = state_q.to_n; // R13 R18
        state_d.rdata[STAT_PD_BIT] = state_q.pd_n; // R18
      end else if (addr_is(reg_req_i.addr, IRQ_CTRL_OFFS)) begin
        state_d.rdata = state_q.irq_ctrl;
      end else if (addr_is(reg_req_i.addr, OPTION_OFFS)) begin
        state_d.rdata = state_q.option;
      end else if (addr_is(reg_req_i.addr, CONFIG_OFFS)) begin
        state_d.rdata = state_q.cfg;
      end else begin
        state_d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      // Every field is listed so that no state can come out of reset unknown.
      state_q.mode        <= MODE_RUN;
      state_q.irq_ctrl    <= IRQ_CTRL_RESET;
      state_q.option      <= OPTION_RESET;
      state_q.cfg         <= 8'h00;
      state_q.cfg_valid   <= 1'b0;
      state_q.to_n        <= 1'b1;
      state_q.pd_n        <= 1'b1; // R18
      state_q.wdt_cnt     <= '0;
      state_q.psc         <= 8'h00;
      state_q.ext_prev    <= 1'b0;
      state_q.pins_prev   <= 3'h0;
      state_q.prev_valid  <= 1'b0;
      state_q.rdata       <= 8'h00;
      state_q.irq_req     <= 1'b0;
      state_q.vector_load <= 1'b0;
      state_q.vector_addr <= 13'h0000;
      state_q.wdt_reset   <= 1'b0;
      state_q.wake        <= 1'b0;
      state_q.osc_stop    <= 1'b0;
      state_q.pin_hold    <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_o = state_q.rdata;
  assign irq_req_o = state_q.irq_req;
  assign vector_load_o = state_q.vector_load;
  assign vector_addr_o = state_q.vector_addr;
  assign wdt_reset_o = state_q.wdt_reset;
  assign wake_o = state_q.wake;
  assign osc_stop_o = state_q.osc_stop;
  assign pin_hold_o = state_q.pin_hold;
endmodule

// ===== rtl/irq_wdt_pkg.sv
// Package with register map, field positions, timing and carrier types of the interrupt and watchdog block.
package irq_wdt_pkg;
  localparam int          ADDR_W           = 14;
  localparam logic [13:0] STATUS_OFFS      = 14'h0003;
  localparam logic [13:0] IRQ_CTRL_OFFS    = 14'h000b;
  localparam logic [13:0] OPTION_OFFS      = 14'h0081;
  localparam logic [13:0] CONFIG_OFFS      = 14'h2007;
  localparam int          FLAG_PORT_BIT    = 0;
  localparam int          FLAG_EXT_BIT     = 1;
  localparam int          FLAG_TMR_BIT     = 2;
  localparam int          EN_PORT_BIT      = 3;
  localparam int          EN_EXT_BIT       = 4;
  localparam int          EN_TMR_BIT       = 5;
  localparam int          EN_PERIPH_BIT    = 6;
  localparam int          GIE_BIT          = 7;
  localparam int          OPT_EDGE_BIT     = 6;
  localparam int          OPT_ASSIGN_BIT   = 3;
  localparam int          OPT_PS_LSB       = 0;
  localparam int          CFG_WDT_EN_BIT   = 3;
  localparam int          STAT_PD_BIT      = 3;
  localparam int          STAT_TO_BIT      = 4;
  localparam logic [7:0]  IRQ_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  OPTION_RESET     = 8'hff;
  localparam logic [12:0] IRQ_VECTOR       = 13'h0004;
  localparam int          WDT_PERIOD_US    = 18000;
  localparam int          CLK_MHZ          = 50;
  localparam int          WDT_CYCLES_NOM   = WDT_PERIOD_US * CLK_MHZ;
  localparam int          WDT_CNT_W        = 20;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_WAKE  = 2'b11
  } mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic sleep;
    logic watchdog_clear_instr;
    logic return_from_irq_instr;
    logic irq_take;
  } core_cmd_t;
endpackage

// ===== verification/core_model.sv
// Core model: answers an interrupt request with one take pulse after a chosen lag.
`timescale 1ns/1ps
module core_model (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       irq_req_i,
  input  wire logic [1:0] lag_i,
  output logic            irq_take_o
);
  logic [1:0] wait_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_q     <= 2'h0;
      irq_take_o <= 1'b0;
    end else begin
      // The take is never repeated back to back, since the request drops a cycle late.
      irq_take_o <= irq_req_i && !irq_take_o && wait_q >= lag_i;
      wait_q     <= (irq_req_i && !irq_take_o) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

// ===== verification/irq_watchdog_sleep_ctrl_bench.sv
// Self-checking bench for the interrupt, watchdog and sleep block.
`timescale 1ns/1ps
module irq_watchdog_sleep_ctrl_bench;
  import irq_wdt_pkg::*;
  localparam int unsigned WDT_CYCLES = 8;
  logic        mclk_i, reset_i, tmr, ext, take, vload, wdt_rst, wake, osc, hold, irq_req, rd_d;
  logic [2:0]  pins;
  logic        adc_done, adc_en, adc_rc;
  logic [7:0]  rdata, cfg;
  logic [12:0] vaddr;
  logic [1:0]  lag;
  reg_req_t    req;
  core_cmd_t   cmd, cmd_w;
  int          errors, checks, lat, cyc;
  logic [7:0]  expq[$];
  assign cmd_w = {cmd.sleep, cmd.watchdog_clear_instr, cmd.return_from_irq_instr, take};
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  irq_watchdog_sleep_ctrl #(.WDT_CYCLES(WDT_CYCLES)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .core_cmd_i(cmd_w), .timer_rollover_i(tmr), .ext_irq_pin_i(ext),
    .port_pin_zero_i(pins[0]), .port_pin_one_i(pins[1]), .port_pin_three_i(pins[2]),
    .conversion_done_flag_i(adc_done), .conversion_irq_enable_i(adc_en),
    .conversion_rc_clock_i(adc_rc), .config_word_i(cfg), .irq_req_o(irq_req),
    .vector_load_o(vload), .vector_addr_o(vaddr), .wdt_reset_o(wdt_rst), .wake_o(wake),
    .osc_stop_o(osc), .pin_hold_o(hold));
  core_model i_core (.mclk_i(mclk_i), .reset_i(reset_i), .irq_req_i(irq_req), .lag_i(lag),
    .irq_take_o(take));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    check_byte(what, {7'h0, exp}, {7'h0, got});
  endtask
  // Read data stand only in the cycle after the strobe, so the oldest note is taken then.
  always @(posedge mclk_i) begin
    if (rd_d && expq.size() > 0)
      check_byte("read data", expq.pop_front(), rdata);
    rd_d <= req.rd;
    cyc  <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic wr_reg(input logic [13:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [13:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    expq.push_back(e);
    @(posedge mclk_i);
    req.rd <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] sel);
    @(posedge mclk_i);
    {cmd.sleep, cmd.watchdog_clear_instr, cmd.return_from_irq_instr, tmr} <= sel;
    @(posedge mclk_i);
    {cmd.sleep, cmd.watchdog_clear_instr, cmd.return_from_irq_instr, tmr} <= 4'h0;
  endtask
  task automatic wait_pulse(input int sel);
    lat = 0;
    do begin
      @(posedge mclk_i);
      #1;
      lat++;
    end while (lat < 2000 && !(sel == 0 ? wake : sel == 1 ? vload : wdt_rst));
  endtask
  task automatic do_reset(input logic [7:0] c);
    reset_i <= 1'b1;
    cfg     <= c;
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  initial begin
    req = '0; cmd = '0; tmr = 1'b0; ext = 1'b0; pins = 3'h0; lag = 2'h0; rd_d = 1'b0;
    errors = 0; checks = 0; cyc = 0; reset_i = 1'b1; cfg = 8'hf7;
    adc_done = 1'b0; adc_en = 1'b0; adc_rc = 1'b0;
    void'($urandom(15));
    do_reset(8'hf7);
    rd_reg(IRQ_CTRL_OFFS, IRQ_CTRL_RESET);
    rd_reg(OPTION_OFFS, OPTION_RESET);
    wr_reg(STATUS_OFFS, 8'h00);
    rd_reg(STATUS_OFFS, 8'h18);
    rd_reg(14'h0055, 8'h00);
    rd_reg(CONFIG_OFFS, 8'hf7);
    $display("reset values done");
    pulse(4'h1);
    rd_reg(IRQ_CTRL_OFFS, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr_reg(OPTION_OFFS, i < 2 ? 8'hff : 8'hbf);
      wr_reg(IRQ_CTRL_OFFS, 8'h00);
      @(posedge mclk_i);
      ext <= ~ext;
      rd_reg(IRQ_CTRL_OFFS, {6'h0, (i == 0 || i == 3), 1'b0});
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(IRQ_CTRL_OFFS, 8'h00);
      @(posedge mclk_i);
      pins <= pins ^ (3'h1 << ($urandom % 3));
      rd_reg(IRQ_CTRL_OFFS, 8'h01);
      rd_reg(IRQ_CTRL_OFFS, 8'h01);
    end
    $display("flag sources done");
    lag <= 2'($urandom);
    wr_reg(IRQ_CTRL_OFFS, 8'ha0);
    pulse(4'h1);
    wait_pulse(1);
    check_bit("vector load", 1'b1, vload);
    check_byte("vector", IRQ_VECTOR[7:0], vaddr[7:0]);
    rd_reg(IRQ_CTRL_OFFS, 8'h24);
    wr_reg(IRQ_CTRL_OFFS, 8'h20);
    pulse(4'h2);
    rd_reg(IRQ_CTRL_OFFS, 8'ha0);
    $display("interrupt take done");
    wr_reg(OPTION_OFFS, 8'hff);
    wr_reg(IRQ_CTRL_OFFS, 8'h10);
    pulse(4'h8);
    @(posedge mclk_i);
    #1;
    check_bit("osc stop", 1'b1, osc);
    check_bit("pin hold", 1'b1, hold);
    rd_reg(STATUS_OFFS, 8'h10);
    @(posedge mclk_i);
    ext <= ~ext;
    wait_pulse(0);
    check_bit("wake", 1'b1, wake);
    check_bit("osc stop", 1'b0, osc);
    rd_reg(IRQ_CTRL_OFFS, 8'h12);
    #1;
    check_bit("irq req", 1'b0, irq_req);
    wait_pulse(2);
    check_bit("wdt quiet", 1'b0, wdt_rst);
    wr_reg(IRQ_CTRL_OFFS, 8'h40);
    pulse(4'h8);
    adc_en   <= 1'b1;
    adc_done <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    check_bit("osc stop", 1'b1, osc);
    adc_rc <= 1'b1;
    wait_pulse(0);
    check_bit("adc wake", 1'b1, wake);
    {adc_done, adc_en, adc_rc} <= 3'h0;
    $display("sleep and pin wake done");
    do_reset(8'h08);
    rd_reg(CONFIG_OFFS, 8'h08);
    for (int ps = 0; ps < 3; ps++) begin
      pulse(4'h4);
      wr_reg(OPTION_OFFS, {4'h0, ps > 0, 3'(ps)});
      pulse(4'h4);
      wait_pulse(2);
      check_bit("wdt period", 1'b1, lat >= (WDT_CYCLES << ps) &&
        lat <= (WDT_CYCLES << ps) + 3);
    end
    rd_reg(STATUS_OFFS, 8'h08);
    rd_reg(OPTION_OFFS, OPTION_RESET);
    $display("watchdog periods done");
    pulse(4'h4);
    wr_reg(OPTION_OFFS, 8'h00);
    pulse(4'h8);
    wait_pulse(0);
    check_bit("wdt wake", 1'b1, wake && lat <= WDT_CYCLES + 4);
    check_bit("wdt reset", 1'b0, wdt_rst);
    rd_reg(STATUS_OFFS, 8'h00);
    $display("watchdog wake done");
    repeat (2) @(posedge mclk_i);
    tally_and_finish();
  end
endmodule
bind irq_watchdog_sleep_ctrl irq_wdt_chk #(.WDT_CYCLES(WDT_CYCLES)) i_chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .core_cmd_i(core_cmd_i), .config_word_i(config_word_i),
  .irq_req_o(irq_req_o), .vector_load_o(vector_load_o), .vector_addr_o(vector_addr_o),
  .wdt_reset_o(wdt_reset_o), .wake_o(wake_o), .osc_stop_o(osc_stop_o),
  .pin_hold_o(pin_hold_o));

// ===== verification/irq_wdt_chk.sv
// Port checker for the interrupt, watchdog and sleep block.
`timescale 1ns/1ps
module irq_wdt_chk
  import irq_wdt_pkg::*;
#(
  parameter int unsigned WDT_CYCLES = 8
) (
  input wire logic                   mclk_i,
  input wire logic                   reset_i,
  input wire irq_wdt_pkg::core_cmd_t core_cmd_i,
  input wire logic [7:0]             config_word_i,
  input wire logic                   irq_req_o,
  input wire logic                   vector_load_o,
  input wire logic [12:0]            vector_addr_o,
  input wire logic                   wdt_reset_o,
  input wire logic                   wake_o,
  input wire logic                   osc_stop_o,
  input wire logic                   pin_hold_o
);
  localparam int unsigned MIN_GAP = WDT_CYCLES - 1;
  // Cycles since the watchdog was last cleared; a timeout may never come sooner.
  logic [31:0] since_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i)
      since_q <= '0;
    else if (core_cmd_i.watchdog_clear_instr || core_cmd_i.sleep || wdt_reset_o)
      since_q <= '0;
    else
      since_q <= since_q + 32'h1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_take_vectors: assert property (core_cmd_i.irq_take && irq_req_o |=>
    vector_load_o && vector_addr_o == IRQ_VECTOR) else $error("vector not loaded after take");
  a_take_drops_req: assert property (vector_load_o |-> !irq_req_o)
    else $error("request still up after take");
  a_sleep_by_cmd: assert property ($rose(osc_stop_o) |-> $past(core_cmd_i.sleep))
    else $error("oscillator stopped without sleep");
  a_hold_with_osc: assert property (pin_hold_o == osc_stop_o)
    else $error("pin hold differs from sleep state");
  a_wake_leaves_sleep: assert property (wake_o |-> $fell(osc_stop_o))
    else $error("wake without leaving sleep");
  a_sleep_no_reset: assert property (osc_stop_o && $past(osc_stop_o) |-> !wdt_reset_o)
    else $error("watchdog reset while asleep");
  a_wdt_off_quiet: assert property (!config_word_i[CFG_WDT_EN_BIT] |-> !wdt_reset_o)
    else $error("disabled watchdog fired");
  a_wdt_min_period: assert property (wdt_reset_o |-> since_q >= MIN_GAP)
    else $error("watchdog timed out early");
  a_no_req_asleep: assert property (osc_stop_o |-> !irq_req_o)
    else $error("interrupt request while asleep");
endmodule
